// [core/seq_pkg.sv]
// Constants and types for the supply sequencer mode controller
`default_nettype none
package seq_pkg;
	localparam int NUM_CH = 6;
	localparam int NUM_MON = 11;
	localparam logic [2:0] LEVEL_ALL = 3'h6;
	localparam logic [3:0] MON_LAST = 4'ha;

	// Time base: one tick every 10 us
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int MON_CYCLE_US = 2000;
	localparam int MON_SLOT_TICKS = (MON_CYCLE_US * 1000 / TICK_NS) / NUM_MON;
	localparam int RST_TO0_US = 640;
	localparam int RST_TO1_US = 25000;
	localparam int RST_TO2_US = 100000;
	localparam int RST_TO3_US = 200000;
	localparam int RST_TO0_TK = (RST_TO0_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int RST_TO1_TK = (RST_TO1_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int RST_TO2_TK = (RST_TO2_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int RST_TO3_TK = (RST_TO3_US * 1000 + TICK_NS - 1) / TICK_NS;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ORDER = 8'h04;
	localparam logic [7:0] ADDR_POL = 8'h08;
	localparam logic [7:0] ADDR_STALL = 8'h0c;
	localparam logic [7:0] ADDR_RST_TO = 8'h10;
	localparam logic [7:0] ADDR_MARGIN = 8'h14;
	localparam logic [7:0] ADDR_M_RST = 8'h18;
	localparam logic [7:0] ADDR_M_GOOD = 8'h1c;
	localparam logic [7:0] ADDR_M_FAULT = 8'h20;
	localparam logic [7:0] ADDR_M_OFF = 8'h24;
	localparam logic [7:0] ADDR_M_SHDN = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2c;

	// Control fields
	localparam int CTRL_REG_EN = 0;
	localparam int CTRL_MARGIN = 1;
	localparam int CTRL_OFF_CMD = 2;

	// Reset values
	localparam logic [17:0] ORDER_RST = 18'h2c688;
	localparam logic [5:0] POL_RST = 6'h3f;
	localparam logic [15:0] STALL_RST = 16'h03e8;
	localparam logic [1:0] RST_TO_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_ON_SEQ  = 3'b001,
		ST_MONITOR = 3'b010,
		ST_MARGIN  = 3'b011,
		ST_OFF_SEQ = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic       power_on_request;
		logic       fs_n;
		logic [5:0] up;
		logic [5:0] down;
	} pin_in_t;

	typedef struct packed {
		logic [10:0] rst;
		logic [10:0] good;
		logic [10:0] fault;
		logic [10:0] off;
		logic [10:0] shdn;
	} mask_t;

	localparam pin_in_t PIN_RST = '{power_on_request: 1'b0, fs_n: 1'b1, up: 6'h0, down: 6'h0};
endpackage
`default_nettype wire

// [core/supply_sequencer_mode_control.sv]
// Mode controller for a six-channel supply sequencer and monitor
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module supply_sequencer_mode_control #(
	parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
	input  wire logic        i_clk,                  // 125 MHz clock
	input  wire logic        i_reset_n,              // Synchronous reset, active low
	input  wire logic [7:0]  i_addr,                 // Register byte address
	input  wire logic [31:0] i_wdata,                // Register write data
	input  wire logic        i_wr,                   // Write strobe
	input  wire logic        i_rd,                   // Read strobe
	output logic      [31:0] o_rdata,                // Read data, cycle after strobe
	input  wire logic        i_power_on_request,     // Power-on request pin level
	output logic             o_power_on_request_oe,  // Pull power-on request low
	input  wire logic        i_forced_shutdown_n,    // Forced-shutdown line level
	output logic             o_forced_shutdown_oe,   // Pull forced-shutdown line low
	input  wire logic [5:0]  i_chan_up,              // Channel above on threshold
	input  wire logic [5:0]  i_chan_down,            // Channel below off threshold
	output logic      [5:0]  o_converter_enable_out, // Converter enables, pin level
	output logic             o_conv_start,           // Start one conversion
	output logic      [3:0]  o_conv_chan,            // Channel to convert
	input  wire logic        i_conv_valid,           // Conversion result ready
	input  wire logic        i_conv_uv,              // Result below undervoltage limit
	input  wire logic        i_conv_ov,              // Result above overvoltage limit
	output logic             o_regulation_en,        // Output regulation loop running
	output logic      [11:0] o_margin_sel,           // Per channel 0 nom, 1 high, 2 low
	output logic             o_supplies_good_out,    // Supplies good, active high
	output logic             o_system_reset_n,       // System reset, active low
	output logic             o_fault_n,              // Fault, active low
	output logic      [1:0]  o_mode                  // 0 on, 1 monitor, 2 margin, 3 off
);
	seq_pkg::seq_state_t state;
	seq_pkg::seq_state_t next_state;
	seq_pkg::pin_in_t    pin_meta;
	seq_pkg::pin_in_t    pin;
	seq_pkg::mask_t      masks;
	logic [2:0]  level;
	logic [2:0]  next_level;
	logic [5:0]  en_q;
	logic [5:0]  next_en;
	logic        pwr_prev;
	logic        reg_en;
	logic [17:0] seq_order;
	logic [5:0]  en_pol;
	logic [15:0] stall_cfg;
	logic [15:0] stall_cnt;
	logic [1:0]  rst_to_sel;
	logic [11:0] margin_cfg;
	logic [10:0] viol;
	logic [10:0] tick_cnt;
	logic        tick;
	logic [4:0]  slot_cnt;
	logic [3:0]  mon_idx;
	logic [14:0] rst_cnt;
	logic [14:0] rst_to_ticks;
	logic        fs_drive;
	logic        up_ok;
	logic        down_ok;
	logic        stall_exp;
	logic        shdn_now;
	logic        pwr_rise;
	logic        pwr_fall;
	logic        off_cmd;
	logic        margin_cmd;
	logic        margin_exit;
	logic        off_trig;
	logic        shdn_trig;
	logic        rst_trig;
	logic        monitoring;

	function automatic logic [1:0] mode_of(input seq_pkg::seq_state_t s);
		case (s)
			seq_pkg::ST_ON_SEQ:  mode_of = 2'h0;
			seq_pkg::ST_MONITOR: mode_of = 2'h1;
			seq_pkg::ST_MARGIN:  mode_of = 2'h2;
			default:             mode_of = 2'h3;
		endcase
	endfunction

	// Two-flop synchronisers for pins
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pin_meta <= seq_pkg::PIN_RST;
			pin <= seq_pkg::PIN_RST;
			pwr_prev <= 1'b0;
		end else begin
			pin_meta <= {i_power_on_request, i_forced_shutdown_n, i_chan_up, i_chan_down};
			pin <= pin_meta;
			pwr_prev <= pin.power_on_request;
		end
	end

	assign pwr_rise = pin.power_on_request && !pwr_prev;
	assign pwr_fall = !pin.power_on_request && pwr_prev;
	assign off_cmd = i_wr && i_addr == seq_pkg::ADDR_CTRL && i_wdata[seq_pkg::CTRL_OFF_CMD];
	assign margin_cmd = i_wr && i_addr == seq_pkg::ADDR_CTRL && i_wdata[seq_pkg::CTRL_MARGIN];
	assign margin_exit = i_wr && i_addr == seq_pkg::ADDR_CTRL && !i_wdata[seq_pkg::CTRL_MARGIN];
	assign monitoring = state == seq_pkg::ST_MONITOR || state == seq_pkg::ST_MARGIN;

	// Register writes
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			reg_en <= 1'b0;
			seq_order <= seq_pkg::ORDER_RST;
			en_pol <= seq_pkg::POL_RST;
			stall_cfg <= seq_pkg::STALL_RST;
			rst_to_sel <= seq_pkg::RST_TO_RST;
			margin_cfg <= 12'h000;
			masks <= '0;
		end else if (i_wr) begin
			case (i_addr)
				seq_pkg::ADDR_CTRL:    reg_en <= i_wdata[seq_pkg::CTRL_REG_EN];
				seq_pkg::ADDR_ORDER:   seq_order <= i_wdata[17:0];
				seq_pkg::ADDR_POL:     en_pol <= i_wdata[5:0];
				seq_pkg::ADDR_STALL:   stall_cfg <= i_wdata[15:0];
				seq_pkg::ADDR_RST_TO:  rst_to_sel <= i_wdata[1:0];
				seq_pkg::ADDR_MARGIN:  margin_cfg <= i_wdata[11:0];
				seq_pkg::ADDR_M_RST:   masks.rst <= i_wdata[10:0];
				seq_pkg::ADDR_M_GOOD:  masks.good <= i_wdata[10:0];
				seq_pkg::ADDR_M_FAULT: masks.fault <= i_wdata[10:0];
				seq_pkg::ADDR_M_OFF:   masks.off <= i_wdata[10:0];
				seq_pkg::ADDR_M_SHDN:  masks.shdn <= i_wdata[10:0];
				default: ;
			endcase
		end
	end

	// Register reads; data stands one cycle only
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0;
		end else if (!i_rd) begin
			o_rdata <= 32'h0;
		end else begin
			case (i_addr)
				seq_pkg::ADDR_CTRL:    o_rdata <= {29'h0, 1'b0, state == seq_pkg::ST_MARGIN, reg_en};
				seq_pkg::ADDR_ORDER:   o_rdata <= {14'h0, seq_order};
				seq_pkg::ADDR_POL:     o_rdata <= {26'h0, en_pol};
				seq_pkg::ADDR_STALL:   o_rdata <= {16'h0, stall_cfg};
				seq_pkg::ADDR_RST_TO:  o_rdata <= {30'h0, rst_to_sel};
				seq_pkg::ADDR_MARGIN:  o_rdata <= {20'h0, margin_cfg};
				seq_pkg::ADDR_M_RST:   o_rdata <= {21'h0, masks.rst};
				seq_pkg::ADDR_M_GOOD:  o_rdata <= {21'h0, masks.good};
				seq_pkg::ADDR_M_FAULT: o_rdata <= {21'h0, masks.fault};
				seq_pkg::ADDR_M_OFF:   o_rdata <= {21'h0, masks.off};
				seq_pkg::ADDR_M_SHDN:  o_rdata <= {21'h0, masks.shdn};
				seq_pkg::ADDR_STATUS:  o_rdata <= {5'h0, viol, 2'h0, !o_fault_n,
					o_supplies_good_out, !o_system_reset_n, en_q, level, o_mode};
				default:               o_rdata <= 32'h0;
			endcase
		end
	end

	// 10 us time base
	assign tick = tick_cnt == 11'(TICK_CYCLES - 1);
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || tick)
			tick_cnt <= 11'h0;
		else
			tick_cnt <= tick_cnt + 11'h1;
	end

	always_comb begin
		up_ok = 1'b1;
		down_ok = 1'b1;
		for (int c = 0; c < seq_pkg::NUM_CH; c++) begin
			if (seq_order[3*c +: 3] == 3'(level - 3'h1) && !pin.up[c])
				up_ok = 1'b0;
			if (seq_order[3*c +: 3] == level && !pin.down[c])
				down_ok = 1'b0;
		end
	end

	// Stall timer, restarted on each step
	assign stall_exp = stall_cfg != 16'h0 && stall_cnt >= stall_cfg;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || next_state != state || next_level != level)
			stall_cnt <= 16'h0;
		else if (tick && !stall_exp)
			stall_cnt <= stall_cnt + 16'h1;
	end

	// triggers only evaluated in monitor state
	assign off_trig = pwr_fall || off_cmd || |(viol & masks.off);
	assign shdn_trig = |(viol & masks.shdn);

	always_comb begin
		next_state = state;
		next_level = level;
		shdn_now = 1'b0;
		if (!pin.fs_n) begin
			next_state = seq_pkg::ST_OFF;
			next_level = 3'h0;
		end else begin
			case (state)
				seq_pkg::ST_OFF: begin
					if (pwr_rise) begin
						next_state = seq_pkg::ST_ON_SEQ;
						next_level = 3'h1;
					end
				end
				seq_pkg::ST_ON_SEQ: begin
					if (stall_exp) begin
						next_state = seq_pkg::ST_OFF;
						next_level = 3'h0;
					end else if (up_ok) begin
						// enter monitor once all supplies are up
						if (level == seq_pkg::LEVEL_ALL)
							next_state = seq_pkg::ST_MONITOR;
						else
							next_level = level + 3'h1;
					end
				end
				seq_pkg::ST_MONITOR: begin
					if (shdn_trig) begin
						shdn_now = 1'b1;
						next_state = seq_pkg::ST_OFF;
						next_level = 3'h0;
					end else if (off_trig) begin
						next_state = seq_pkg::ST_OFF_SEQ;
						next_level = level - 3'h1;
					end else if (margin_cmd) begin
						next_state = seq_pkg::ST_MARGIN;
					end
				end
				seq_pkg::ST_MARGIN: begin
					if (margin_exit)
						next_state = seq_pkg::ST_MONITOR;
				end
				seq_pkg::ST_OFF_SEQ: begin
					if (stall_exp) begin
						shdn_now = 1'b1;
						next_state = seq_pkg::ST_OFF;
						next_level = 3'h0;
					end else if (down_ok) begin
						if (level == 3'h0)
							next_state = seq_pkg::ST_OFF;
						else
							next_level = level - 3'h1;
					end
				end
				default: begin
					next_state = seq_pkg::ST_OFF;
					next_level = 3'h0;
				end
			endcase
		end
	end

	always_comb begin
		for (int c = 0; c < seq_pkg::NUM_CH; c++)
			next_en[c] = seq_order[3*c +: 3] < next_level;
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state <= seq_pkg::ST_OFF;
			level <= 3'h0;
			en_q <= 6'h0;
			o_converter_enable_out <= ~seq_pkg::POL_RST;
			o_mode <= 2'h3;
		end else begin
			state <= next_state;
			level <= next_level;
			en_q <= next_en;
			o_converter_enable_out <= ~(next_en ^ en_pol);
			o_mode <= mode_of(next_state);
		end
	end

	// Drive shutdown line for one tick; pull request low while it is low
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			fs_drive <= 1'b0;
			o_power_on_request_oe <= 1'b0;
		end else begin
			if (shdn_now)
				fs_drive <= 1'b1;
			else if (tick)
				fs_drive <= 1'b0;
			o_power_on_request_oe <= shdn_now || fs_drive || !pin.fs_n;
		end
	end
	assign o_forced_shutdown_oe = fs_drive;

	// conversion scheduler, one slot per channel
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !monitoring) begin
			slot_cnt <= 5'h0;
			mon_idx <= 4'h0;
			o_conv_start <= 1'b0;
			o_conv_chan <= 4'h0;
		end else begin
			o_conv_start <= 1'b0;
			if (tick) begin
				if (slot_cnt == 5'(seq_pkg::MON_SLOT_TICKS - 1)) begin
					slot_cnt <= 5'h0;
					o_conv_start <= 1'b1;
					o_conv_chan <= mon_idx;
					mon_idx <= mon_idx == seq_pkg::MON_LAST ? 4'h0 : mon_idx + 4'h1;
				end else begin
					slot_cnt <= slot_cnt + 5'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !monitoring)
			viol <= 11'h0;
		else if (i_conv_valid && o_conv_chan <= seq_pkg::MON_LAST)
			viol[o_conv_chan] <= i_conv_uv || i_conv_ov;
	end

	always_comb begin
		case (rst_to_sel)
			2'h0:    rst_to_ticks = 15'(seq_pkg::RST_TO0_TK);
			2'h1:    rst_to_ticks = 15'(seq_pkg::RST_TO1_TK);
			2'h2:    rst_to_ticks = 15'(seq_pkg::RST_TO2_TK);
			default: rst_to_ticks = 15'(seq_pkg::RST_TO3_TK);
		endcase
	end

	assign rst_trig = !monitoring || (state == seq_pkg::ST_MONITOR && |(viol & masks.rst));

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_system_reset_n <= 1'b0;
			rst_cnt <= 15'h0;
		end else if (state == seq_pkg::ST_MARGIN) begin
			o_system_reset_n <= 1'b1;
			rst_cnt <= 15'h0;
		end else if (rst_trig) begin
			o_system_reset_n <= 1'b0;
			rst_cnt <= 15'h0;
		end else if (!o_system_reset_n && tick) begin
			if (rst_cnt >= rst_to_ticks - 15'h1)
				o_system_reset_n <= 1'b1;
			else
				rst_cnt <= rst_cnt + 15'h1;
		end
	end

	// good and fault outputs; regulation targets
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_supplies_good_out <= 1'b0;
			o_fault_n <= 1'b1;
			o_regulation_en <= 1'b0;
			o_margin_sel <= 12'h000;
		end else begin
			o_supplies_good_out <= state == seq_pkg::ST_MARGIN ||
				(state == seq_pkg::ST_MONITOR && !(|(viol & masks.good)));
			o_fault_n <= !(monitoring && |(viol & masks.fault));
			o_regulation_en <= reg_en && (next_state == seq_pkg::ST_MONITOR ||
				next_state == seq_pkg::ST_MARGIN);
			o_margin_sel <= next_state == seq_pkg::ST_MARGIN ? margin_cfg : 12'h000;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_margin_held;
		state == seq_pkg::ST_MARGIN [*2];
	endsequence
	sequence s_on_held;
		state == seq_pkg::ST_ON_SEQ [*2];
	endsequence

	a_on_start: assert property (
		state == seq_pkg::ST_OFF && pwr_rise && pin.fs_n |=> state == seq_pkg::ST_ON_SEQ)
		else $error("power-on edge did not start sequencing");
	a_cascade_hold: assert property (
		state == seq_pkg::ST_ON_SEQ && !up_ok && pin.fs_n && !stall_exp |=> $stable(level))
		else $error("slot advanced before supplies reached threshold");
	a_stall_on: assert property (
		state == seq_pkg::ST_ON_SEQ && stall_exp |=> state == seq_pkg::ST_OFF && en_q == 6'h0)
		else $error("stalled power-on left channels enabled");
	a_on_outputs: assert property (
		s_on_held |-> !o_supplies_good_out && !o_system_reset_n)
		else $error("good or reset wrong during power-on");
	a_margin_outputs: assert property (
		s_margin_held |-> o_supplies_good_out && o_system_reset_n)
		else $error("good or reset wrong in margining");
	a_off_entry: assert property (
		state != seq_pkg::ST_MONITOR && state != seq_pkg::ST_OFF_SEQ
		|=> state != seq_pkg::ST_OFF_SEQ)
		else $error("power-off entered outside monitor mode");
	a_off_start: assert property (
		state == seq_pkg::ST_MONITOR && pin.fs_n && !shdn_trig && off_cmd
		|=> state == seq_pkg::ST_OFF_SEQ ##0 !o_regulation_en ##1 !o_regulation_en)
		else $error("power-off did not stop regulation");
	a_shutdown_line: assert property (
		!pin.fs_n |=> en_q == 6'h0 && o_power_on_request_oe)
		else $error("shutdown line did not drop enables");
	a_no_seq_faults: assert property (
		!monitoring [*2] |-> viol == 11'h0 && o_fault_n)
		else $error("faults evaluated during sequencing");
	a_conv_spacing: assert property (
		o_conv_start |=> !o_conv_start [*8])
		else $error("conversions started too close together");
endmodule
`default_nettype wire

// [tb/conv_model.sv]
// Behavioural converters and monitor converter facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module conv_model (
	input  wire logic       i_clk,   // Clock
	input  wire logic [5:0] i_pin,   // Enable pin levels
	input  wire logic [5:0] i_pol,   // Active level per channel
	input  wire logic       i_start, // Conversion start
	input  wire logic       i_bad,   // Report next result out of limit
	output logic      [5:0] o_up,    // Above on threshold
	output logic      [5:0] o_down,  // Below off threshold
	output logic            o_valid, // Result ready
	output logic            o_uv,    // Below limit
	output logic            o_ov     // Above limit
);
	logic [5:0] dly [4];
	logic [1:0] busy;

	initial begin
		dly = '{default: 6'h0};
		busy = 2'h0;
		o_valid = 1'b0;
		o_uv = 1'b0;
		o_ov = 1'b1;
	end
	// Supplies settle four cycles after their enable moves
	always @(posedge i_clk) begin
		dly[0] <= ~(i_pin ^ i_pol);
		for (int k = 1; k < 4; k++) dly[k] <= dly[k-1];
	end
	assign o_up = dly[3];
	assign o_down = ~dly[3];
	// Result four cycles after start, in limit unless i_bad; junk between results
	always @(posedge i_clk) begin
		busy <= i_start ? 2'h3 : (busy != 2'h0 ? busy - 2'h1 : busy);
		o_valid <= (busy == 2'h1);
		o_uv <= (busy == 2'h1) ? i_bad : ~o_uv;
		o_ov <= (busy == 2'h1) ? 1'b0 : ~o_ov;
	end
endmodule
`default_nettype wire

// [tb/tb_supply_sequencer_mode_control.sv]
// Self-checking bench for the supply sequencer mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_supply_sequencer_mode_control;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [7:0]  i_addr = 8'h0;
	logic [31:0] i_wdata = 32'h0;
	logic        req_low = 1'b1;
	logic        fs_low = 1'b0;
	logic        bad = 1'b0;
	logic [5:0]  pol = 6'h3f;
	logic [5:0]  up, down, en_pin;
	logic [31:0] o_rdata;
	logic        req_oe, fs_oe, cstart, cvalid, cuv, cov, reg_en, good, rst_n, fault_n;
	logic [3:0]  cchan, c0;
	logic [11:0] msel, ms;
	logic [1:0]  mode;
	logic        req_wire, fs_wire;
	logic        rd_seen = 1'b0;
	logic [31:0] rd_q [$];
	int          bad_count = 0;
	int          compares = 0;
	int          order [$];
	int          gap;

	assign req_wire = !req_low && !req_oe;
	assign fs_wire = !fs_low && !fs_oe;
	always #4 i_clk = ~i_clk;

	supply_sequencer_mode_control #(.TICK_CYCLES(4)) dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_on_request(req_wire),
		.o_power_on_request_oe(req_oe), .i_forced_shutdown_n(fs_wire),
		.o_forced_shutdown_oe(fs_oe), .i_chan_up(up), .i_chan_down(down),
		.o_converter_enable_out(en_pin), .o_conv_start(cstart), .o_conv_chan(cchan),
		.i_conv_valid(cvalid), .i_conv_uv(cuv), .i_conv_ov(cov), .o_regulation_en(reg_en),
		.o_margin_sel(msel), .o_supplies_good_out(good), .o_system_reset_n(rst_n),
		.o_fault_n(fault_n), .o_mode(mode));

	conv_model partner (
		.i_clk(i_clk), .i_pin(en_pin), .i_pol(pol), .i_start(cstart), .i_bad(bad), .o_up(up),
		.o_down(down), .o_valid(cvalid), .o_uv(cuv), .o_ov(cov));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge i_clk) rd_seen <= i_rd;
	always @(negedge i_clk) if (rd_seen) check("rdata", rd_q.pop_front(), o_rdata);

	// Follow a sequence to mode m, noting the order enables move in
	task automatic run_seq(input logic [1:0] m, input bit down_dir);
		logic [5:0] prev, en;
		prev = ~(en_pin ^ pol);
		order = {};
		for (int n = 0; n < 2000 && (mode !== m || order.size() < 6); n++) begin
			@(negedge i_clk);
			en = ~(en_pin ^ pol);
			for (int c = 0; c < 6; c++) if (en[c] !== prev[c]) order.push_back(c);
			prev = en;
			// good low, reset held in power-on
			if (mode === 2'h0) check("good_rst", 32'h0, {good, rst_n});
		end
		check("mode", m, mode);
		check("steps", 6, order.size());
		for (int i = 0; i < 6 && i < order.size(); i++)
			check("order", down_dir ? 5 - i : i, order[i]);
	endtask

	initial begin
		#400000;
		bad_count++;
		final_report();
	end

	initial begin
		void'($urandom(74));
		repeat (12) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(seq_pkg::ADDR_ORDER, {14'h0, seq_pkg::ORDER_RST});
		rd(seq_pkg::ADDR_POL, {26'h0, seq_pkg::POL_RST});
		rd(seq_pkg::ADDR_STALL, {16'h0, seq_pkg::STALL_RST});
		rd(8'h30, 32'h0);
		pol = 6'($urandom);
		wr(seq_pkg::ADDR_POL, {26'h0, pol});
		wr(seq_pkg::ADDR_CTRL, 32'h3);
		repeat (3) @(negedge i_clk);
		check("mode", 3, mode);
		wr(seq_pkg::ADDR_CTRL, 32'h1);
		@(negedge i_clk);
		check("idle_en", {26'h0, ~pol}, en_pin);
		$display("test reset and idle done");
		@(posedge i_clk) req_low <= 1'b0;
		run_seq(2'h1, 1'b0);
		check("en_all", {26'h0, pol}, en_pin);
		check("reg_en", 1, reg_en);
		check("rst_n", 0, rst_n);
		repeat (200) @(negedge i_clk);
		check("rst_n", 0, rst_n);
		repeat (100) @(negedge i_clk);
		check("rst_n", 1, rst_n);
		// slots of 18 ticks, channels in turn
		for (int n = 0; n < 200 && cstart !== 1'b1; n++) @(negedge i_clk);
		c0 = cchan;
		@(negedge i_clk);
		for (gap = 1; gap < 200 && cstart !== 1'b1; gap++) @(negedge i_clk);
		check("slot", 72, gap);
		check("chan", (c0 == 4'ha) ? 0 : c0 + 1, cchan);
		$display("test power-on done");
		for (int c = 0; c < 6; c++) ms[2*c +: 2] = 2'($urandom % 3);
		wr(seq_pkg::ADDR_MARGIN, {20'h0, ms});
		wr(seq_pkg::ADDR_CTRL, 32'h3);
		repeat (3) @(negedge i_clk);
		check("mode", 2, mode);
		check("msel", ms, msel);
		check("good_rst", 32'h3, {good, rst_n});
		rd(seq_pkg::ADDR_CTRL, 32'h3);
		@(posedge i_clk) req_low <= 1'b1;
		repeat (20) @(negedge i_clk);
		check("mode", 2, mode);
		check("en_all", {26'h0, pol}, en_pin);
		@(posedge i_clk) req_low <= 1'b0;
		wr(seq_pkg::ADDR_CTRL, 32'h1);
		repeat (3) @(negedge i_clk);
		check("mode", 1, mode);
		check("msel", 0, msel);
		$display("test margining done");
		// limit violations drive good and fault
		wr(seq_pkg::ADDR_M_GOOD, 32'h7ff);
		wr(seq_pkg::ADDR_M_FAULT, 32'h7ff);
		@(posedge i_clk) bad <= 1'b1;
		for (int n = 0; n < 100 && fault_n !== 1'b0; n++) @(negedge i_clk);
		@(negedge i_clk);
		check("good_fault", 32'h0, {good, fault_n});
		@(posedge i_clk) bad <= 1'b0;
		$display("test limits done");
		@(posedge i_clk) req_low <= 1'b1;
		run_seq(2'h3, 1'b1);
		check("reg_en", 0, reg_en);
		check("en_off", {26'h0, ~pol}, en_pin);
		repeat (20) @(negedge i_clk);
		rd(seq_pkg::ADDR_STATUS, 32'h803);
		$display("test power-off done");
		@(posedge i_clk) req_low <= 1'b0;
		run_seq(2'h1, 1'b0);
		@(posedge i_clk) fs_low <= 1'b1;
		repeat (4) @(negedge i_clk);
		check("fs_en", {26'h0, ~pol}, en_pin);
		check("req_oe", 1, req_oe);
		check("mode", 3, mode);
		@(posedge i_clk) fs_low <= 1'b0;
		$display("test forced shutdown done");
		run_seq(2'h1, 1'b0);
		wr(seq_pkg::ADDR_CTRL, 32'h5);
		run_seq(2'h3, 1'b1);
		repeat (20) @(negedge i_clk);
		rd(seq_pkg::ADDR_STATUS, 32'h803);
		$display("test host power-off done");
		// stalled power-on falls back to idle
		wr(seq_pkg::ADDR_STALL, 32'h1);
		@(posedge i_clk) req_low <= 1'b1;
		repeat (4) @(negedge i_clk);
		@(posedge i_clk) req_low <= 1'b0;
		for (int n = 0; n < 50 && mode !== 2'h0; n++) @(negedge i_clk);
		check("mode", 0, mode);
		repeat (20) @(negedge i_clk);
		rd(seq_pkg::ADDR_STATUS, 32'h803);
		$display("test stall done");
		final_report();
	end
endmodule
`default_nettype wire
